// *** hw/mscan_latency_line.sv ***
`timescale 1ns/10ps
// Fixed-length delay line; every stage is a register, so the tail is registered
module mscan_latency_line
  import mscan_pkg::*;
#(
  parameter int DEPTH = OUTPUT_LATENCY - 1  // Stages; the caller adds one capture stage
) (
  // Clock and reset
  input wire logic     sys_clk,
  input wire logic     resetn,
  // Tagged samples
  mscan_dline_if.line  dl
);

  localparam int WORD_W = SAMPLE_W + 5;  // Code, channel, marker, valid

  logic [WORD_W-1:0] stage [DEPTH];      // Delay stages

  // Stage 0 takes the new sample, every later stage its neighbour
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_stage
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          stage[gi] <= '0;
        end else if (gi == 0) begin
          stage[gi] <= {dl.in_valid, dl.in_marker, dl.in_chan, dl.in_code};
        end else begin
          stage[gi] <= stage[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  // Tail of the line
  assign dl.out_code   = stage[DEPTH-1][SAMPLE_W-1:0];
  assign dl.out_chan   = stage[DEPTH-1][SAMPLE_W+2:SAMPLE_W];
  assign dl.out_marker = stage[DEPTH-1][SAMPLE_W+3];
  assign dl.out_valid  = stage[DEPTH-1][SAMPLE_W+4];

endmodule

// *** hw/mscan_sequencer.sv ***
`timescale 1ns/10ps
module mscan_sequencer
  import mscan_pkg::*;
#(
  parameter int STAGES = PIPE_STAGES  // Converter pipeline stages, two code bits each
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  // Register port from the serial interface
  input  wire logic                  reg_wr_en,
  input  wire logic                  reg_rd_en,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wr_data,
  output      logic [7:0]            reg_rd_data,
  // Settings decoded by the serial interface
  input  wire logic                  impedance_high_setting,
  input  wire logic [1:0]            gain_code,
  input  wire logic                  cutoff_quarter_setting,
  input  wire logic [2:0]            cutoff_scale_code,
  input  wire logic                  filter_tuning_setting,
  input  wire logic                  stabilizer_enable_setting,
  input  wire logic                  power_down_setting,
  input  wire logic                  clock_rate_changed,
  // Device pins
  input  wire logic                  impedance_select_pin,
  input  wire logic                  first_channel_force_pin,
  input  wire logic                  aux_force_pin,
  input  wire logic                  full_power_down_pin,
  // Converter pipeline stage codes, first stage in the top bits
  input  wire logic [2*STAGES-1:0]   stage_codes,
  // Analog control
  output      logic [2:0]            mux_channel,
  output      logic [NUM_CHANNELS-1:0] channel_powered,
  output      logic                  converter_powered,
  output      logic                  impedance_high,
  output      logic [5:0]            channel_gain_db,
  output      logic [2:0]            cutoff_divisor,
  output      logic [3:0]            cutoff_scale_tenths,
  output      logic                  filter_tuning_on,
  output      logic                  duty_cycle_stabilizer,
  // Status
  output      logic                  stabilizer_locked,
  output      logic [2:0]            enabled_count,
  // Parallel sample bus
  output      logic [SAMPLE_W-1:0]   sample_data,
  output      logic                  sample_valid,
  output      logic                  sample_settled,
  output      logic [2:0]            sample_channel,
  output      logic                  channel_a_frame_marker
);

  // Pin synchronisers, two stages each
  logic [3:0]            pin_meta;          // First stage, read only by the second
  logic [3:0]            pin_sync;          // Second stage, safe to use
  logic                  impedance_select_pin_s;            // Impedance pin, synchronised
  logic                  force_a_s;         // Channel A force pin, synchronised
  logic                  force_aux_s;       // Aux force pin, synchronised
  logic                  full_power_down_pin_s;            // Power-down pin, synchronised

  // Register and derived scan configuration
  logic [7:0]            channel_scan_select;  // Scan select register
  logic [6:0]            code_mask;         // Channels named by the mux code
  logic [6:0]            scan_mask;         // Channels actually scanned
  logic                  marker_allowed;    // More than a lone A or aux channel

  // Sequencer
  mscan_state_t          state;             // Run state
  mscan_state_t          next_state;        // Next run state
  logic [2:0]            next_channel;      // Channel to sample on the next clock
  logic                  first_of_scan;     // Current channel is the first enabled one

  // Converter word and stabilizer
  logic [SAMPLE_W:0]     combined;          // Sum of stage codes, one guard bit
  logic [SAMPLE_W-1:0]   corrected;         // Saturated result
  logic [3:0]            lock_count;        // Cycles since the last rate change or fresh enable, held at the lock count
  logic                  stab_enable_d;     // Stabilizer enable, one clock late

  // Latency line carrier
  mscan_dline_if         dl ();

  // Two-flop synchronisers for all asynchronous pins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {full_power_down_pin, aux_force_pin, first_channel_force_pin,
                   impedance_select_pin};
      pin_sync <= pin_meta;
    end
  end

  assign impedance_select_pin_s      = pin_sync[0];
  assign force_a_s   = pin_sync[1];
  assign force_aux_s = pin_sync[2];
  assign full_power_down_pin_s      = pin_sync[3];

  // Scan select register; reserved bits are never stored, so they read zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      channel_scan_select <= SCAN_SELECT_RESET;
    end else if (reg_wr_en && (reg_addr == SCAN_SELECT_ADDR)) begin
      channel_scan_select <= reg_wr_data & SCAN_SELECT_WMASK;
    end
  end

  // Read back; unmapped addresses answer zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rd_data <= (reg_addr == SCAN_SELECT_ADDR) ? channel_scan_select : 8'h00;
    end
  end

  // Decode the mux code into a channel mask
  // Auxiliary sits at the highest index, so it always closes a scan
  always_comb begin
    logic [3:0] code;
    code      = channel_scan_select[SCAN_CODE_LSB +: SCAN_CODE_W];
    code_mask = MASK_A_ONLY;
    case (code)
      CODE_ALL_AMPLIFIED: code_mask = MASK_A_TO_F;
      CODE_ALL_WITH_AUX:  code_mask = MASK_A_TO_F | MASK_AUX;
      CODE_AUX_ONLY:      code_mask = MASK_AUX;
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
        // A up to the channel the code names
        code_mask = 7'((8'h02 << code) - 8'h01);
      end
      4'h6, 4'h7, 4'h8, 4'h9: begin
        // A up to a channel, plus auxiliary last
        code_mask = 7'((8'h02 << (code - CODE_AUX_BASE)) - 8'h01) | MASK_AUX;
      end
      default: code_mask = MASK_A_ONLY;
    endcase
  end

  // Force pins override the register; aux force outranks channel A force
  always_comb begin
    if (force_aux_s) begin
      scan_mask = MASK_AUX;
    end else if (force_a_s) begin
      scan_mask = MASK_A_ONLY;
    end else begin
      scan_mask = code_mask;
    end
  end

  // Marker only makes sense when a frame holds more than one channel
  assign marker_allowed = (scan_mask != MASK_A_ONLY) && (scan_mask != MASK_AUX);

  // Number of scanned channels: each channel sees the clock divided by it
  always_comb begin
    logic [2:0] cnt;
    cnt = 3'h0;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      cnt = cnt + {2'b00, scan_mask[i]};
    end
    enabled_count = cnt;
  end

  // Next enabled channel after the current one, wrapping to the lowest
  // A mask change mid-scan simply continues from the current position
  always_comb begin
    logic found;
    logic [2:0] lowest;
    found        = 1'b0;
    lowest       = CHAN_A;
    next_channel = CHAN_A;
    for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
      if (scan_mask[i]) begin
        lowest = 3'(i);
      end
    end
    for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
      if (scan_mask[i] && (3'(i) > mux_channel)) begin
        next_channel = 3'(i);
        found        = 1'b1;
      end
    end
    if (!found) begin
      next_channel = lowest;
    end
  end

  // First enabled channel opens the scan; it is A whenever A is scanned
  always_comb begin
    logic any_lower;
    any_lower = 1'b0;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (scan_mask[i] && (3'(i) < mux_channel)) begin
        any_lower = 1'b1;
      end
    end
    first_of_scan = !any_lower;
  end

  // Run state: the power-down pin or setting stops the scan entirely
  always_comb begin
    next_state = state;
    case (state)
      MS_DOWN: begin
        if (!full_power_down_pin_s && !power_down_setting) begin
          next_state = MS_SCAN;
        end
      end
      MS_SCAN: begin
        if (full_power_down_pin_s || power_down_setting) begin
          next_state = MS_DOWN;
        end
      end
      default: next_state = MS_DOWN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= MS_DOWN;
    end else begin
      state <= next_state;
    end
  end

  // Mux pointer: one clock on each channel, moved on the sampling edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mux_channel <= CHAN_A;
    end else if (state == MS_SCAN) begin
      mux_channel <= next_channel;
    end else begin
      // Park on the first enabled channel, never on a dead one
      mux_channel <= scan_mask[CHAN_A] ? CHAN_A : next_channel;
    end
  end

  // Channel power: unselected stages off unless the keep-powered bit is set
  always_comb begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      channel_powered[i] = (state == MS_SCAN) &&
                           (scan_mask[i] || channel_scan_select[KEEP_POWERED_BIT]);
    end
  end

  assign converter_powered = (state == MS_SCAN);

  // Combine the stage codes; each stage carries weight of half its predecessor
  // The overlap between stages is what lets the sum correct early decisions
  always_comb begin
    logic [SAMPLE_W:0] acc;
    acc = '0;
    for (int i = 0; i < STAGES; i++) begin
      acc = acc + ((SAMPLE_W+1)'(stage_codes[2*(STAGES-1-i) +: 2]) << (STAGES-1-i));
    end
    combined = acc;
  end

  // Clip to full scale rather than wrap at the top code
  assign corrected = combined[SAMPLE_W] ? {SAMPLE_W{1'b1}} : combined[SAMPLE_W-1:0];

  // Feed the line with the sample taken on this rising edge
  assign dl.in_valid  = (state == MS_SCAN);
  assign dl.in_chan   = mux_channel;
  assign dl.in_code   = corrected;
  assign dl.in_marker = (state == MS_SCAN) && first_of_scan &&
                        (mux_channel == CHAN_A) && marker_allowed;

  // Six stages in the line plus the output register make seven clocks
  mscan_latency_line #(
    .DEPTH (OUTPUT_LATENCY - 1)
  ) u_line (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .dl      (dl)
  );

  // Output register drives the parallel bus
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sample_data            <= '0;
      sample_valid           <= 1'b0;
      sample_channel         <= CHAN_A;
      channel_a_frame_marker <= 1'b0;
    end else begin
      sample_data            <= dl.out_code;
      sample_valid           <= dl.out_valid;
      sample_channel         <= dl.out_chan;
      channel_a_frame_marker <= dl.out_marker;
    end
  end

  // Stabilizer lock counter, restarted by a rate change or a fresh enable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stab_enable_d <= 1'b0;
    end else begin
      stab_enable_d <= stabilizer_enable_setting;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lock_count <= 4'h0;
    end else if (clock_rate_changed ||
                 (stabilizer_enable_setting && !stab_enable_d)) begin
      lock_count <= 4'h0;
    end else if (lock_count != DCS_LOCK_CYCLES) begin
      lock_count <= lock_count + 4'h1;
    end
  end

  // Data is settled once locked, or at once when the stabilizer is off
  assign stabilizer_locked     = (lock_count == DCS_LOCK_CYCLES);
  assign duty_cycle_stabilizer = stabilizer_enable_setting;
  assign sample_settled        = sample_valid &&
                                 (stabilizer_locked || !stabilizer_enable_setting);

  // Input impedance: the pin can only raise it, never lower it
  assign impedance_high = impedance_select_pin_s || impedance_high_setting;

  // Gain: 16 dB plus 6 dB per code step, 34 dB at the top code
  assign channel_gain_db = GAIN_DB_MIN + 6'(gain_code * GAIN_DB_STEP);

  // Default cutoff divisor of the sample clock
  assign cutoff_divisor = cutoff_quarter_setting ? CUTOFF_DIV_FOURTH
                                                 : CUTOFF_DIV_THIRD;

  // Scale codes beyond the last multiplier fall back to unity
  assign cutoff_scale_tenths = (cutoff_scale_code <= CUTOFF_CODE_MAX) ?
                               CUTOFF_TENTHS_MIN + {1'b0, cutoff_scale_code} :
                               CUTOFF_TENTHS_NOM;

  // Tuning follows its setting, but only while scanning; nothing else may start it,
  // and power-down stops it. The setting is expected to reset to off.
  assign filter_tuning_on = filter_tuning_setting && (state == MS_SCAN);

endmodule

// *** shared/mscan_dline_if.sv ***
`timescale 1ns/10ps
// Carries tagged samples into and out of the latency line
interface mscan_dline_if;
  import mscan_pkg::*;
  logic                in_valid;   // A sample was taken this clock
  logic [2:0]          in_chan;    // Channel that was sampled
  logic [SAMPLE_W-1:0] in_code;    // Corrected result of that sample
  logic                in_marker;  // Sample opens a frame
  logic                out_valid;  // Delayed valid
  logic [2:0]          out_chan;   // Delayed channel
  logic [SAMPLE_W-1:0] out_code;   // Delayed result
  logic                out_marker; // Delayed frame marker
  modport feeder (output in_valid, in_chan, in_code, in_marker,
                  input  out_valid, out_chan, out_code, out_marker);
  modport line   (input  in_valid, in_chan, in_code, in_marker,
                  output out_valid, out_chan, out_code, out_marker);
endinterface

// *** shared/mscan_pkg.sv ***
package mscan_pkg;

  // Register map of the serial-port register space
  localparam logic [7:0] SCAN_SELECT_ADDR  = 8'h0C;  // Channel scan select register
  localparam logic [7:0] SCAN_SELECT_RESET = 8'h0A;  // Reset value: channels A to F
  localparam logic [7:0] SCAN_SELECT_WMASK = 8'h4F;  // Implemented bits; the rest read 0
  localparam int         SCAN_CODE_LSB     = 0;      // Mux code field, low bit
  localparam int         SCAN_CODE_W       = 4;      // Mux code field width
  localparam int         KEEP_POWERED_BIT  = 6;      // Keep unselected channels powered

  // Mux codes
  localparam logic [3:0] CODE_ALL_AMPLIFIED = 4'hA;  // Channels A to F
  localparam logic [3:0] CODE_ALL_WITH_AUX  = 4'hB;  // Channels A to F plus auxiliary
  localparam logic [3:0] CODE_AUX_ONLY      = 4'hC;  // Auxiliary channel alone
  localparam logic [3:0] CODE_AUX_BASE      = 4'h6;  // First code of the "A.. plus aux" set

  // Channel numbering: scan order is index order, auxiliary last
  localparam int         NUM_CHANNELS = 7;
  localparam logic [2:0] CHAN_A       = 3'h0;
  localparam logic [2:0] CHAN_AUX     = 3'h6;
  localparam logic [6:0] MASK_A_ONLY  = 7'h01;
  localparam logic [6:0] MASK_AUX     = 7'h40;
  localparam logic [6:0] MASK_A_TO_F  = 7'h3F;

  // Converter
  localparam int SAMPLE_W        = 12;  // Result width
  localparam int PIPE_STAGES     = 11;  // Pipeline stages, two code bits each
  localparam int OUTPUT_LATENCY  = 7;   // Sample clocks from sampling to bus

  // Gain table, channel gain in dB per gain code
  localparam logic [5:0] GAIN_DB_MIN  = 6'h10;  // 16 dB
  localparam logic [5:0] GAIN_DB_STEP = 6'h06;  // 6 dB per code step, 34 dB at code 3

  // Filter cutoff scaling, multiplier in tenths per scale code 0..6
  localparam logic [3:0] CUTOFF_TENTHS_MIN = 4'h7;  // 0.7 times default
  localparam logic [2:0] CUTOFF_CODE_MAX   = 3'h6;  // 1.3 times default
  localparam logic [3:0] CUTOFF_TENTHS_NOM = 4'hA;  // 1.0 times default
  localparam logic [2:0] CUTOFF_DIV_THIRD  = 3'h3;  // Default cutoff: clock / 3
  localparam logic [2:0] CUTOFF_DIV_FOURTH = 3'h4;  // Default cutoff: clock / 4

  // Duty-cycle stabilizer lock time, in sample clock cycles
  localparam logic [3:0] DCS_LOCK_CYCLES = 4'h8;

  // Sequencer run state
  typedef enum logic [1:0] {
    MS_DOWN = 2'b00,
    MS_SCAN = 2'b01
  } mscan_state_t;

endpackage

// *** verif/mscan_capture_model.sv ***
`timescale 1ns/10ps
// Capture side: counts settled words between frame markers
module mscan_capture_model (
  // Clock and reset
  input  logic       sys_clk,
  input  logic       resetn,
  // Sample bus from the device
  input  logic       sample_settled,
  input  logic       channel_a_frame_marker,
  // Words seen in the last whole frame
  output logic [3:0] frame_words
);
  logic [3:0] run;  // Words since the last marker

  // Frame length is the per-channel rate divisor; unsettled words other than the marker word are not counted
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run         <= 4'h0;
      frame_words <= 4'h0;
    end else if (channel_a_frame_marker) begin
      frame_words <= run;
      run         <= 4'h1;
    end else if (sample_settled) begin
      run <= run + 4'h1;
    end
  end
endmodule

// *** verif/mscan_seq_props.sv ***
`timescale 1ns/10ps
// Port-level checks of scan order, latency and controls
module mscan_seq_props
  import mscan_pkg::*;
(
  // Clock and reset
  input logic       sys_clk,
  input logic       resetn,
  // Settings and pins
  input logic       impedance_high_setting,
  input logic       filter_tuning_setting,
  input logic       stabilizer_enable_setting,
  input logic       clock_rate_changed,
  input logic       impedance_select_pin,
  input logic       full_power_down_pin,
  // Analog control and status
  input logic [2:0] mux_channel,
  input logic [6:0] channel_powered,
  input logic       converter_powered,
  input logic       impedance_high,
  input logic       filter_tuning_on,
  input logic       stabilizer_locked,
  input logic [2:0] enabled_count,
  // Sample bus
  input logic       sample_valid,
  input logic       sample_settled,
  input logic [2:0] sample_channel,
  input logic       channel_a_frame_marker
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // Marker only rides on a channel A word
  AST_MARKER_ON_A: assert property (
    channel_a_frame_marker |-> sample_valid && sample_channel == CHAN_A)
    else $error("Marker without A word");
  // Bus word names the channel sampled seven clocks earlier
  AST_BUS_LATENCY: assert property (
    sample_valid |-> sample_channel == $past(mux_channel, 7))
    else $error("Bus latency wrong");
  // With several channels the mux never stays two clocks
  AST_DWELL_ONE: assert property (
    converter_powered && $past(converter_powered) && enabled_count > 3'h1
      && $past(enabled_count) > 3'h1 |-> mux_channel != $past(mux_channel))
    else $error("Mux dwelt too long");
  // Aux is last, so A follows it
  AST_AUX_WRAP: assert property (
    converter_powered && mux_channel == CHAN_AUX && enabled_count > 3'h1 |=> mux_channel == CHAN_A)
    else $error("No wrap after aux");
  // Eight lone-channel clocks flush older frames
  AST_SINGLE_NO_MARK: assert property (
    (enabled_count == 3'h1) [*8] |-> !channel_a_frame_marker)
    else $error("Marker on lone channel");
  AST_IMP_REG: assert property (
    impedance_high_setting |-> impedance_high)
    else $error("Impedance setting ignored");
  // Pin passes a two-stage synchroniser first
  AST_IMP_PIN: assert property (
    impedance_select_pin [*3] |-> impedance_high)
    else $error("Impedance pin ignored");
  AST_TUNE_GATED: assert property (
    filter_tuning_on |-> filter_tuning_setting)
    else $error("Tuning without setting");
  // Lock follows a rate change after about eight clocks
  AST_LOCK_TIME: assert property (
    stabilizer_enable_setting && clock_rate_changed
      |=> !stabilizer_locked [*7] ##[1:2] stabilizer_locked)
    else $error("Lock time wrong");
  // Words before lock are never flagged settled
  AST_SETTLED: assert property (
    stabilizer_enable_setting && clock_rate_changed
      |=> (!sample_settled || !stabilizer_enable_setting) [*7])
    else $error("Settled before lock");
  AST_PIN_POWER_DOWN: assert property (
    full_power_down_pin [*4] |-> !converter_powered && channel_powered == '0)
    else $error("Power-down pin ignored");
endmodule

// *** verif/test_multichannel_adc_scan_sequencer.sv ***
`timescale 1ns/10ps
// Bench for the scan sequencer
module test_multichannel_adc_scan_sequencer;
  import mscan_pkg::*;
  // Clock, reset and tallies
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  int   err_total = 0;
  int   cmp_count = 0;
  // Register port and settings
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, impedance_high_setting = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00;
  logic [1:0] gain_code = 2'h0;
  logic [2:0] cutoff_scale_code = 3'h0;
  logic cutoff_quarter_setting = 1'b0, filter_tuning_setting = 1'b0;
  logic stabilizer_enable_setting = 1'b0, power_down_setting = 1'b0, clock_rate_changed = 1'b0;
  // Pins and converter stage codes
  logic impedance_select_pin = 1'b0, first_channel_force_pin = 1'b0;
  logic aux_force_pin = 1'b0, full_power_down_pin = 1'b0;
  logic [21:0] stage_codes = 22'h155555;
  // Outputs
  logic [7:0] reg_rd_data;
  logic [2:0] mux_channel, cutoff_divisor, enabled_count, sample_channel;
  logic [6:0] channel_powered;
  logic [5:0] channel_gain_db;
  logic [3:0] cutoff_scale_tenths, frame_words;
  logic [11:0] sample_data;
  logic converter_powered, impedance_high, filter_tuning_on, duty_cycle_stabilizer;
  logic stabilizer_locked, sample_valid, sample_settled, channel_a_frame_marker;

  always #50 sys_clk = ~sys_clk;

  mscan_sequencer mscan_sequencer_inst (.*);
  mscan_capture_model mscan_capture_model_inst (.sys_clk, .resetn, .sample_settled,
    .channel_a_frame_marker, .frame_words);

  // Count one comparison, report a mismatch
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Inputs always change 1 ns after the edge
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    cyc(1);
    reg_wr_en = 1'b0;
  endtask
  // Read data is registered at the strobe edge
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    cyc(1);
    reg_rd_en = 1'b0;
    chk("reg_rd_data", reg_rd_data, exp);
  endtask
  // Channel set of each mux code
  function automatic logic [6:0] code_mask(logic [3:0] c);
    if (c < 4'h6) return 7'h7F >> (4'h6 - c);
    if (c < 4'hA) return (7'h7F >> (4'hC - c)) | MASK_AUX;
    case (c)
      4'hA: return MASK_A_TO_F;
      4'hB: return 7'h7F;
      4'hC: return MASK_AUX;
      default: return MASK_A_ONLY;
    endcase
  endfunction
  // Next enabled channel, wrapping to the lowest
  function automatic logic [2:0] next_ch(logic [6:0] m, logic [2:0] p);
    int c;
    for (int i = 1; i <= 7; i++) begin
      c = (p + i) % 7;
      if (m[c]) return 3'(c);
    end
    return p;
  endfunction
  // Flush the pipeline, then follow 16 words
  task automatic check_scan(logic [6:0] m);
    logic [2:0] prev;
    logic       multi;
    multi = (m != MASK_A_ONLY) && (m != MASK_AUX);
    cyc(10);
    prev = sample_channel;
    repeat (16) begin
      cyc(1);
      chk("sample_valid", sample_valid, 1);
      chk("sample_channel", sample_channel, next_ch(m, prev));
      chk("marker", channel_a_frame_marker, multi && sample_channel == CHAN_A);
      prev = sample_channel;
    end
    chk("enabled_count", enabled_count, $countones(m));
    if (multi) chk("frame_words", frame_words, $countones(m));
  endtask

  task automatic t_settings();
    filter_tuning_setting = 1'b1;
    cyc(1);
    chk("filter_tuning_on", filter_tuning_on, 1);
    filter_tuning_setting = 1'b0;
    for (int g = 0; g < 4; g++) begin
      gain_code = 2'(g);
      cyc(1);
      chk("channel_gain_db", channel_gain_db, 16 + 6 * g);
    end
    for (int s = 0; s < 16; s++) begin
      cutoff_scale_code = 3'(s);
      cutoff_quarter_setting = s[3];
      cyc(1);
      chk("cutoff_divisor", cutoff_divisor, s[3] ? 4 : 3);
      chk("cutoff_tenths", cutoff_scale_tenths, (s % 8 == 7) ? 10 : 7 + s % 8);
    end
    chk("filter_tuning_on", filter_tuning_on, 0);
    impedance_high_setting = 1'b1;
    cyc(1);
    chk("impedance_high", impedance_high, 1);
    impedance_high_setting = 1'b0;
    impedance_select_pin = 1'b1;
    cyc(3);
    chk("impedance_high", impedance_high, 1);
    impedance_select_pin = 1'b0;
    cyc(3);
    chk("impedance_high", impedance_high, 0);
    stabilizer_enable_setting = 1'b1;
    cyc(12);
    clock_rate_changed = 1'b1;
    cyc(1);
    clock_rate_changed = 1'b0;
    chk("duty_cycle_stabilizer", duty_cycle_stabilizer, 1);
    chk("sample_settled", sample_settled, 0);
    cyc(10);
    chk("sample_settled", sample_settled, 1);
    stabilizer_enable_setting = 1'b0;
    cyc(1);
    chk("duty_cycle_stabilizer", duty_cycle_stabilizer, 0);
    $display("Settings done");
  endtask

  task automatic t_scan();
    rd(SCAN_SELECT_ADDR, SCAN_SELECT_RESET);
    for (int c = 0; c < 16; c++) begin
      wr(SCAN_SELECT_ADDR, 8'(c));
      check_scan(code_mask(4'(c)));
      chk("channel_powered", channel_powered, code_mask(4'(c)));
    end
    wr(SCAN_SELECT_ADDR, 8'hFF);
    rd(SCAN_SELECT_ADDR, SCAN_SELECT_WMASK);
    chk("channel_powered", channel_powered, 7'h7F);
    wr(8'h0D, 8'hFF);
    rd(8'h0D, 8'h00);
    wr(SCAN_SELECT_ADDR, 8'h0A);
    rd(SCAN_SELECT_ADDR, 8'h0A);
    $display("Scan done");
  endtask

  task automatic t_pins_power();
    aux_force_pin = 1'b1;
    first_channel_force_pin = 1'b1;
    check_scan(MASK_AUX);
    aux_force_pin = 1'b0;
    check_scan(MASK_A_ONLY);
    first_channel_force_pin = 1'b0;
    full_power_down_pin = 1'b1;
    cyc(12);
    chk("converter_powered", converter_powered, 0);
    chk("channel_powered", channel_powered, 0);
    chk("sample_valid", sample_valid, 0);
    full_power_down_pin = 1'b0;
    power_down_setting = 1'b1;
    cyc(4);
    chk("converter_powered", converter_powered, 0);
    power_down_setting = 1'b0;
    check_scan(MASK_A_TO_F);
    $display("Pin test done");
  endtask

  // Weighted stage sum, clipped at full scale
  task automatic t_data();
    logic [21:0] pat [4] = '{22'h155555, 22'h3FFFFF, 22'h000001, 22'h200000};
    logic [12:0] sum;
    foreach (pat[k]) begin
      stage_codes = pat[k];
      sum = 13'h0000;
      for (int i = 0; i < PIPE_STAGES; i++) sum += 13'(pat[k][21-2*i -: 2]) << (10 - i);
      if (sum > 13'h0FFF) sum = 13'h0FFF;
      cyc(10);
      chk("sample_data", sample_data, sum[11:0]);
    end
    $display("Data done");
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    cyc(8);
    resetn = 1'b1;
    t_settings();
    t_scan();
    t_pins_power();
    t_data();
    stop_test();
  end
  // Run is near 630 clocks; 20000 means a hang
  initial begin
    #2000000;
    err_total++;
    stop_test();
  end
endmodule

bind mscan_sequencer mscan_seq_props mscan_seq_props_inst (.sys_clk, .resetn,
  .impedance_high_setting, .filter_tuning_setting, .stabilizer_enable_setting,
  .clock_rate_changed, .impedance_select_pin, .full_power_down_pin, .mux_channel,
  .channel_powered, .converter_powered, .impedance_high, .filter_tuning_on, .stabilizer_locked,
  .enabled_count, .sample_valid, .sample_settled, .sample_channel, .channel_a_frame_marker);
